// *** t16oc_top.v ***
// Purpose: Two output compare channels for a 16-bit timer/counter.
// Assumes: Bus strobes and timer signals are synchronous to clk.
// Notes: Counter, prescaler and input capture live outside this block.
//
// Function
// [RQ1] Compare full count with value every cycle.
// [RQ2] Two independent channels A and B.
// [RQ3] Match flag sets one timer tick later.
// [RQ4] Enabled flag requests irq; ack clears.
// [RQ5] Writing one clears flag; zero ignored.
// [RQ6] Output state from match, mode, action.
// [RQ7] Channel A value can be ceiling.
// [RQ8] Buffered in PWM, direct otherwise.
// [RQ9] Buffer loads only at ceiling or floor.
// [RQ10] CPU accesses buffer or active value.
// [RQ11] Only CPU writes; high byte read directly.
// [RQ12] High byte latched; low write updates all.
// [RQ13] Force updates output, not flag or counter.
// [RQ14] Counter write blocks next tick's matches.
// [RQ15] Blocked variable ceiling match lets count run.
// [RQ16] Software sets output before pin direction.
// [RQ17] Output state kept across modes, reset zero.
// [RQ18] Action field unbuffered, acts next match.
// [RQ19] Nonzero action overrides port value on pin.
// [RQ20] Action zero never changes output state.
// [RQ21] Action field ignores input capture.
// [RQ22] Mode 4 clears counter on A match.
// [RQ23] Mode 0 counts up, wraps freely.
// [RQ24] Force strobes pulse only, ignored in PWM.
`timescale 1ns/100ps
`include "t16oc_consts.vh"
module t16oc_top #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Counter interface
  input wire [WIDTH-1:0] timer_count,
  input wire timer_tick,
  input wire count_ceiling,
  input wire count_floor,
  input wire count_down,
  input wire counter_write,
  // Mode
  input wire [3:0] waveform_mode_select,
  input wire [1:0] compare_output_action_a,
  input wire [1:0] compare_output_action_b,
  // CPU compare value writes
  input wire [7:0] cpu_wdata,
  input wire wr_compare_value_high,
  input wire wr_compare_value_low_a,
  input wire wr_compare_value_low_b,
  // Force strobes
  input wire force_compare_strobe_a,
  input wire force_compare_strobe_b,
  // Flags and interrupts
  input wire compare_match_irq_enable_a,
  input wire compare_match_irq_enable_b,
  input wire flag_write_one_a,
  input wire flag_write_one_b,
  input wire irq_ack_a,
  input wire irq_ack_b,
  // Pin logic
  input wire port_value_a,
  input wire port_value_b,
  input wire output_pin_direction_bit_a,
  input wire output_pin_direction_bit_b,
  // Readback
  output reg [7:0] compare_value_low_a,
  output reg [7:0] compare_value_high_a,
  output reg [7:0] compare_value_low_b,
  output reg [7:0] compare_value_high_b,
  output reg compare_match_flag_a,
  output reg compare_match_flag_b,
  output reg compare_irq_a,
  output reg compare_irq_b,
  output reg compare_output_state_a,
  output reg compare_output_state_b,
  // Counter control
  output reg counter_clear,
  output reg ceiling_match_a,
  // Pins
  output reg pin_out_a,
  output reg pin_out_b,
  output reg pin_oe_a,
  output reg pin_oe_b
);
  // =====================================================================
  // Mode decode
  function is_pwm;
    input [3:0] mode;
    begin
      is_pwm = !((mode == `T16OC_MODE_NORMAL) || (mode == `T16OC_MODE_CTC_A) ||
        (mode == `T16OC_MODE_CTC_ICR) || (mode == `T16OC_MODE_RSVD));
    end
  endfunction

  function is_fast;
    input [3:0] mode;
    begin
      is_fast = (mode == `T16OC_MODE_FAST_8) || (mode == `T16OC_MODE_FAST_9) ||
        (mode == `T16OC_MODE_FAST_10) || (mode == `T16OC_MODE_FAST_ICR) ||
        (mode == `T16OC_MODE_FAST_A);
    end
  endfunction

  function a_is_top;
    input [3:0] mode;
    begin
      a_is_top = (mode == `T16OC_MODE_CTC_A) || (mode == `T16OC_MODE_FAST_A) ||
        (mode == `T16OC_MODE_PC_A) || (mode == `T16OC_MODE_PFC_A);
    end
  endfunction

  wire pwm;
  wire fast;
  wire floor_update;
  wire buf_update;

  assign pwm = is_pwm(waveform_mode_select); // [RQ8]
  assign fast = is_fast(waveform_mode_select);
  // Frequency correct modes reload at the floor so both slopes match.
  assign floor_update = (waveform_mode_select == `T16OC_MODE_PFC_ICR) ||
    (waveform_mode_select == `T16OC_MODE_PFC_A);
  assign buf_update = timer_tick &&
    (floor_update ? count_floor : count_ceiling); // [RQ9]

  // =====================================================================
  // Shared high-byte latch
  reg [7:0] high_latch;

  always @(posedge clk)
  begin
    if (rst)
      high_latch <= `T16OC_BYTE_RESET;
    else if (wr_compare_value_high)
      high_latch <= cpu_wdata; // [RQ12]
  end

  // =====================================================================
  // Match blocking after a counter write
  // The hold survives a stopped timer clock until the next tick uses it.
  reg block_pending;

  always @(posedge clk)
  begin
    if (rst)
      block_pending <= 1'b0;
    else if (counter_write)
      block_pending <= 1'b1; // [RQ14]
    else if (timer_tick)
      block_pending <= 1'b0;
  end

  // =====================================================================
  // Channel bundles
  wire [1:0] wr_low;
  wire [1:0] force_in;
  wire [1:0] irq_en;
  wire [1:0] clr_write;
  wire [1:0] ack;
  wire [3:0] action;
  wire [1:0] port_val;
  wire [1:0] dir_bit;
  wire [2*WIDTH-1:0] active;
  wire [2*WIDTH-1:0] readback;
  wire [1:0] equal;
  wire [1:0] match;
  wire [1:0] state;
  wire [1:0] next_flag;

  assign wr_low = {wr_compare_value_low_b, wr_compare_value_low_a};
  assign force_in = {force_compare_strobe_b, force_compare_strobe_a};
  assign irq_en = {compare_match_irq_enable_b, compare_match_irq_enable_a};
  assign clr_write = {flag_write_one_b, flag_write_one_a};
  assign ack = {irq_ack_b, irq_ack_a};
  assign action = {compare_output_action_b, compare_output_action_a}; // [RQ18]
  assign port_val = {port_value_b, port_value_a};
  assign dir_bit = {output_pin_direction_bit_b, output_pin_direction_bit_a};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_ch // [RQ2]
      reg match_seen;
      reg flag_bit;
      reg next_flag_bit;

      t16oc_cmp_reg #(
        .WIDTH(WIDTH)
      ) u_cmp (
        .clk(clk),
        .rst(rst),
        .buffered(pwm), // [RQ8]
        .load(wr_low[ch]), // [RQ11]
        .wdata({high_latch, cpu_wdata}), // [RQ12]
        .update(buf_update),
        .active(active[ch*WIDTH +: WIDTH]),
        .readback(readback[ch*WIDTH +: WIDTH])
      );

      assign equal[ch] = (timer_count == active[ch*WIDTH +: WIDTH]); // [RQ1]
      assign match[ch] = equal[ch] && timer_tick && !block_pending; // [RQ14]

      t16oc_wave u_wave (
        .clk(clk),
        .rst(rst),
        .pwm(pwm),
        .fast(fast),
        .toggle_ok((ch == 0) && a_is_top(waveform_mode_select)),
        .action(action[2*ch +: 2]), // [RQ21]
        .match(match[ch]), // [RQ6]
        .force_match(force_in[ch] && !pwm), // [RQ24]
        .floor_tick(timer_tick && count_floor),
        .count_down(count_down),
        .state(state[ch])
      );

      always @(posedge clk)
      begin
        if (rst)
          match_seen <= 1'b0;
        else if (timer_tick)
          match_seen <= match[ch]; // [RQ3]
      end

      // A new match outranks a clear landing in the same cycle.
      always @*
      begin
        next_flag_bit = flag_bit;
        if (ack[ch] || clr_write[ch]) // [RQ4] [RQ5]
          next_flag_bit = 1'b0;
        if (timer_tick && match_seen) // [RQ3]
          next_flag_bit = 1'b1;
      end

      assign next_flag[ch] = next_flag_bit;

      always @(posedge clk)
      begin
        if (rst)
          flag_bit <= 1'b0;
        else
          flag_bit <= next_flag_bit;
      end
    end
  endgenerate

  // =====================================================================
  // Ceiling handling for channel A
  // A blocked match is simply absent, so the counter runs on to the max.
  wire next_ceiling_match;
  wire next_counter_clear;

  assign next_ceiling_match = match[0] && a_is_top(waveform_mode_select); // [RQ7] [RQ15]
  assign next_counter_clear = next_ceiling_match &&
    (waveform_mode_select == `T16OC_MODE_CTC_A); // [RQ22] [RQ23]

  // =====================================================================
  // Registered outputs
  always @(posedge clk)
  begin
    if (rst)
    begin
      compare_value_low_a <= `T16OC_BYTE_RESET;
      compare_value_high_a <= `T16OC_BYTE_RESET;
      compare_value_low_b <= `T16OC_BYTE_RESET;
      compare_value_high_b <= `T16OC_BYTE_RESET;
      compare_match_flag_a <= 1'b0;
      compare_match_flag_b <= 1'b0;
      compare_irq_a <= 1'b0;
      compare_irq_b <= 1'b0;
      compare_output_state_a <= 1'b0;
      compare_output_state_b <= 1'b0;
      counter_clear <= 1'b0;
      ceiling_match_a <= 1'b0;
      pin_out_a <= 1'b0;
      pin_out_b <= 1'b0;
      pin_oe_a <= 1'b0;
      pin_oe_b <= 1'b0;
    end
    else
    begin
      // High bytes come straight from the register, not the shared latch.
      compare_value_low_a <= readback[7:0];
      compare_value_high_a <= readback[15:8]; // [RQ11]
      compare_value_low_b <= readback[WIDTH+7:WIDTH];
      compare_value_high_b <= readback[WIDTH+15:WIDTH+8]; // [RQ11]
      compare_match_flag_a <= next_flag[0];
      compare_match_flag_b <= next_flag[1];
      compare_irq_a <= next_flag[0] && irq_en[0]; // [RQ4]
      compare_irq_b <= next_flag[1] && irq_en[1]; // [RQ4]
      compare_output_state_a <= state[0];
      compare_output_state_b <= state[1];
      counter_clear <= next_counter_clear; // [RQ22]
      ceiling_match_a <= next_ceiling_match; // [RQ15]
      pin_out_a <= (action[1:0] != `T16OC_ACT_NONE) ? state[0] : port_val[0]; // [RQ19]
      pin_out_b <= (action[3:2] != `T16OC_ACT_NONE) ? state[1] : port_val[1]; // [RQ19]
      pin_oe_a <= dir_bit[0]; // [RQ19]
      pin_oe_b <= dir_bit[1]; // [RQ19]
    end
  end
endmodule // t16oc_top

// *** t16oc_consts.vh ***
// Purpose: Named constants for the 16-bit timer output compare block.
// Assumes: Included by bare name from every design file of the block.
// Notes: Definitions only.
`ifndef T16OC_CONSTS_VH
`define T16OC_CONSTS_VH
// =====================================================================
// Waveform mode select codes
`define T16OC_MODE_NORMAL 4'h0
`define T16OC_MODE_CTC_A 4'h4
`define T16OC_MODE_CTC_ICR 4'hc
`define T16OC_MODE_RSVD 4'hd
`define T16OC_MODE_PFC_ICR 4'h8
`define T16OC_MODE_PFC_A 4'h9
`define T16OC_MODE_PC_A 4'hb
`define T16OC_MODE_FAST_8 4'h5
`define T16OC_MODE_FAST_9 4'h6
`define T16OC_MODE_FAST_10 4'h7
`define T16OC_MODE_FAST_ICR 4'he
`define T16OC_MODE_FAST_A 4'hf
// =====================================================================
// Output action codes
`define T16OC_ACT_NONE 2'h0
`define T16OC_ACT_TOGGLE 2'h1
`define T16OC_ACT_CLEAR 2'h2
`define T16OC_ACT_SET 2'h3
// =====================================================================
// Reset values and maximum count
`define T16OC_CMP_RESET 16'h0000
`define T16OC_BYTE_RESET 8'h00
`define T16OC_MAX_COUNT 16'hffff
`endif

// *** t16oc_cmp_reg.v ***
// Purpose: One compare value with optional double buffer.
// Assumes: Writes arrive as full 16-bit words in one clock.
// Notes: Readback shows the buffer while buffering, else the active value.
`timescale 1ns/100ps
`include "t16oc_consts.vh"
module t16oc_cmp_reg #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire buffered,
  input wire load,
  input wire [WIDTH-1:0] wdata,
  input wire update,
  // Results
  output reg [WIDTH-1:0] active,
  output reg [WIDTH-1:0] readback
);
  reg [WIDTH-1:0] buffer;
  wire [WIDTH-1:0] next_buffer;
  wire [WIDTH-1:0] next_active;

  // =====================================================================
  // Buffer and active value
  assign next_buffer = (load && buffered) ? wdata : buffer; // [RQ10]
  assign next_active = (load && !buffered) ? wdata : // [RQ10]
    ((buffered && update) ? buffer : active); // [RQ9]

  always @(posedge clk)
  begin
    if (rst)
    begin
      buffer <= `T16OC_CMP_RESET;
      active <= `T16OC_CMP_RESET;
      readback <= `T16OC_CMP_RESET;
    end
    else
    begin
      buffer <= next_buffer;
      active <= next_active;
      readback <= buffered ? next_buffer : next_active; // [RQ10]
    end
  end
endmodule // t16oc_cmp_reg

// *** t16oc_wave.v ***
// Purpose: Output state of one compare channel.
// Assumes: match is a single-cycle pulse on a timer tick; force is a single-cycle pulse on any cycle.
// Notes: State holds across mode changes; reset clears it to zero.
`timescale 1ns/100ps
`include "t16oc_consts.vh"
module t16oc_wave (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Mode
  input wire pwm,
  input wire fast,
  input wire toggle_ok,
  input wire [1:0] action,
  // Events
  input wire match,
  input wire force_match,
  input wire floor_tick,
  input wire count_down,
  // Result
  output reg state
);
  reg next_state;

  // =====================================================================
  // Action decode
  always @*
  begin
    next_state = state;
    if (!pwm)
    begin
      if (match || force_match) // [RQ13]
      begin
        case (action) // [RQ6]
          `T16OC_ACT_TOGGLE: next_state = ~state;
          `T16OC_ACT_CLEAR: next_state = 1'b0;
          `T16OC_ACT_SET: next_state = 1'b1;
          default: next_state = state; // [RQ20]
        endcase
      end
    end
    else if (fast)
    begin
      case (action) // [RQ6]
        `T16OC_ACT_TOGGLE: next_state = (match && toggle_ok) ? ~state : state;
        `T16OC_ACT_CLEAR: next_state = match ? 1'b0 : (floor_tick ? 1'b1 : state);
        `T16OC_ACT_SET: next_state = match ? 1'b1 : (floor_tick ? 1'b0 : state);
        default: next_state = state; // [RQ20]
      endcase
    end
    else if (match)
    begin
      // Dual slope: direction picks the edge of the pulse.
      case (action) // [RQ6]
        `T16OC_ACT_TOGGLE: next_state = toggle_ok ? ~state : state;
        `T16OC_ACT_CLEAR: next_state = count_down;
        `T16OC_ACT_SET: next_state = ~count_down;
        default: next_state = state; // [RQ20]
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (rst)
      state <= 1'b0; // [RQ17]
    else
      state <= next_state; // [RQ17]
  end
endmodule // t16oc_wave

// *** t16oc_checker_assertions.sv ***
// Purpose: Port-level checks for the output compare block.
// Assumes: One clock; rst is synchronous and active high.
// Notes: Only channel A is watched here, since B shares its logic.
`timescale 1ns/100ps
// ==========
// Checker
module t16oc_checker (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Stimulus
  input wire timer_tick,
  input wire [3:0] waveform_mode_select,
  input wire [7:0] cpu_wdata,
  input wire wr_compare_value_low_a,
  input wire flag_write_one_a,
  input wire irq_ack_a,
  input wire [1:0] compare_output_action_a,
  input wire port_value_a,
  // Observed
  input wire [7:0] compare_value_low_a,
  input wire compare_match_flag_a,
  input wire compare_output_state_a,
  input wire pin_out_a
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_low_write;
    wr_compare_value_low_a && waveform_mode_select == 4'h0;
  endsequence
  sequence s_flag_clear;
    compare_match_flag_a && (flag_write_one_a || irq_ack_a) && !timer_tick;
  endsequence
  a_reset_zero: assert property (disable iff (1'b0) rst |=> !compare_output_state_a)
    else $error("output state not zero after reset");
  a_flag_on_tick: assert property ($rose(compare_match_flag_a) |-> $past(timer_tick))
    else $error("flag set off a timer tick");
  a_flag_holds: assert property (compare_match_flag_a && !flag_write_one_a
    && !irq_ack_a |=> compare_match_flag_a)
    else $error("flag dropped without a clear");
  a_flag_clears: assert property (s_flag_clear |=> !compare_match_flag_a)
    else $error("flag not cleared");
  a_readback_low: assert property (s_low_write |-> ##2
    compare_value_low_a == $past(cpu_wdata, 2))
    else $error("low byte readback wrong");
  a_pin_port: assert property (!$past(rst) && $past(compare_output_action_a) == 2'h0
    |-> pin_out_a == $past(port_value_a))
    else $error("pin not from port value");
  a_pin_state: assert property (!$past(rst) && $past(compare_output_action_a) != 2'h0
    |-> pin_out_a == compare_output_state_a)
    else $error("pin not from output state");
  a_action_none: assert property (!$past(rst) && !$past(rst, 2)
    && $past(compare_output_action_a, 2) == 2'h0 |-> $stable(compare_output_state_a))
    else $error("output state moved with no action");
endmodule // t16oc_checker

// *** t16oc_cpu_model.sv ***
// Purpose: Processor side that writes compare values byte by byte.
// Assumes: put is called just after a rising clock edge.
// Notes: Between writes the data bus shows inverted bytes, never a stale value.
`timescale 1ns/100ps
// ==========
// Processor model
module t16oc_cpu_model (
  // Clock
  input wire clk,
  // Compare writes
  output logic [7:0] cpu_wdata,
  output logic wr_compare_value_high,
  output logic wr_compare_value_low_a,
  output logic wr_compare_value_low_b
);
  initial
  begin
    cpu_wdata = 8'h5a;
    {wr_compare_value_high, wr_compare_value_low_a, wr_compare_value_low_b} = 3'h0;
  end
  task automatic put(input logic ch, input logic [15:0] v);
    @(posedge clk);
    #1;
    cpu_wdata = v[15:8];
    wr_compare_value_high = 1'b1;
    @(posedge clk);
    #1;
    wr_compare_value_high = 1'b0;
    cpu_wdata = v[7:0];
    wr_compare_value_low_a = !ch;
    wr_compare_value_low_b = ch;
    @(posedge clk);
    #1;
    {wr_compare_value_low_a, wr_compare_value_low_b} = 2'h0;
    cpu_wdata = ~v[7:0];
  endtask
endmodule // t16oc_cpu_model

// *** t16oc_top_test.sv ***
// Purpose: Self-checking bench for the output compare block.
// Assumes: The bench plays counter and pin logic; the model writes values.
// Notes: Ticks are at least two clocks apart from each other so results have settled.
`timescale 1ns/100ps
`include "t16oc_consts.vh"
// ==========
// Bench
module t16oc_top_test;
  logic clk, rst, timer_tick, count_ceiling, count_floor, count_down, counter_write;
  logic [15:0] timer_count;
  logic [3:0] waveform_mode_select;
  logic [1:0] compare_output_action_a, compare_output_action_b;
  logic [7:0] cpu_wdata, compare_value_low_a, compare_value_high_a;
  logic [7:0] compare_value_low_b, compare_value_high_b;
  logic wr_compare_value_high, wr_compare_value_low_a, wr_compare_value_low_b;
  logic force_compare_strobe_a, force_compare_strobe_b;
  logic compare_match_irq_enable_a, compare_match_irq_enable_b;
  logic flag_write_one_a, flag_write_one_b, irq_ack_a, irq_ack_b;
  logic port_value_a, port_value_b, output_pin_direction_bit_a, output_pin_direction_bit_b;
  logic compare_match_flag_a, compare_match_flag_b, compare_irq_a, compare_irq_b;
  logic compare_output_state_a, compare_output_state_b, counter_clear, ceiling_match_a;
  logic pin_out_a, pin_out_b, pin_oe_a, pin_oe_b;
  int fails, check_count;
  t16oc_top u_t16oc_top (.*);
  t16oc_cpu_model u_t16oc_cpu_model (.*);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tick(input logic [15:0] v);
    timer_count = v;
    timer_tick = 1'b1;
    step(1);
    timer_tick = 1'b0;
    step(1);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_write;
    chk("reset state", 0, compare_output_state_a);
    u_t16oc_cpu_model.put(1'b0, 16'h1234);
    u_t16oc_cpu_model.put(1'b1, 16'h0abc);
    step(1);
    chk("value a", 16'h1234, {compare_value_high_a, compare_value_low_a});
    chk("value b", 16'h0abc, {compare_value_high_b, compare_value_low_b});
    $display("write test done");
  endtask
  task automatic t_match;
    compare_output_action_a = `T16OC_ACT_TOGGLE;
    compare_output_action_b = `T16OC_ACT_TOGGLE;
    {compare_match_irq_enable_a, compare_match_irq_enable_b} = 2'b11;
    tick(16'h1334);
    chk("near miss", 0, compare_output_state_a);
    tick(16'h1234);
    chk("toggled", 1, compare_output_state_a);
    chk("flag early", 0, compare_match_flag_a);
    chk("no clear", 0, counter_clear);
    tick(16'h1235);
    chk("flag a", 1, compare_match_flag_a);
    chk("irq a", 1, compare_irq_a);
    chk("flag b", 0, compare_match_flag_b);
    irq_ack_a = 1'b1;
    step(1);
    irq_ack_a = 1'b0;
    step(1);
    chk("acked", 0, compare_match_flag_a);
    tick(16'h1234);
    tick(16'h1235);
    flag_write_one_a = 1'b1;
    step(1);
    flag_write_one_a = 1'b0;
    step(1);
    chk("written", 0, compare_match_flag_a);
    chk("toggled back", 0, compare_output_state_a);
    $display("match test done");
  endtask
  task automatic t_force;
    compare_output_action_a = `T16OC_ACT_SET;
    {force_compare_strobe_a, force_compare_strobe_b} = 2'b11;
    step(1);
    {force_compare_strobe_a, force_compare_strobe_b} = 2'b00;
    tick(16'h0001);
    chk("forced a", 1, compare_output_state_a);
    chk("forced b", 1, compare_output_state_b);
    chk("forced flag", 0, compare_match_flag_a);
    waveform_mode_select = `T16OC_MODE_FAST_A;
    compare_output_action_a = `T16OC_ACT_CLEAR;
    force_compare_strobe_a = 1'b1;
    step(1);
    force_compare_strobe_a = 1'b0;
    step(2);
    chk("pwm force", 1, compare_output_state_a);
    waveform_mode_select = `T16OC_MODE_NORMAL;
    compare_output_action_a = `T16OC_ACT_TOGGLE;
    counter_write = 1'b1;
    step(1);
    counter_write = 1'b0;
    step(2);
    tick(16'h1234);
    tick(16'h1235);
    chk("blocked state", 1, compare_output_state_a);
    chk("blocked flag", 0, compare_match_flag_a);
    $display("force test done");
  endtask
  task automatic t_action;
    compare_output_action_a = `T16OC_ACT_NONE;
    tick(16'h1234);
    chk("none", 1, compare_output_state_a);
    compare_output_action_a = `T16OC_ACT_CLEAR;
    tick(16'h1234);
    chk("cleared", 0, compare_output_state_a);
    waveform_mode_select = `T16OC_MODE_CTC_A;
    // The clear pulse stands for one cycle only, so look right after the tick edge.
    timer_count = 16'h1234;
    timer_tick = 1'b1;
    step(1);
    timer_tick = 1'b0;
    chk("ctc clear", 1, counter_clear);
    chk("ceiling a", 1, ceiling_match_a);
    step(1);
    chk("clear pulse", 0, counter_clear);
    {output_pin_direction_bit_a, output_pin_direction_bit_b} = 2'b11;
    {port_value_a, port_value_b} = 2'b10;
    compare_output_action_b = `T16OC_ACT_NONE;
    step(2);
    chk("pin a", 0, pin_out_a);
    chk("pin b", 0, pin_out_b);
    chk("oe a", 1, pin_oe_a);
    chk("oe b", 1, pin_oe_b);
    compare_output_action_a = `T16OC_ACT_NONE;
    step(2);
    chk("pin port", 1, pin_out_a);
    tick(16'h0abc);
    tick(16'h0abd);
    chk("irq b", 1, compare_irq_b);
    chk("none b", 1, compare_output_state_b);
    $display("action test done");
  endtask
  task automatic t_pwm;
    compare_output_action_a = `T16OC_ACT_TOGGLE;
    u_t16oc_cpu_model.put(1'b0, 16'h2000);
    step(1);
    chk("buffer", 16'h2000, {compare_value_high_a, compare_value_low_a});
    tick(16'h2000);
    chk("held", 0, compare_output_state_a);
    count_ceiling = 1'b1;
    tick(16'h3000);
    count_ceiling = 1'b0;
    tick(16'h2000);
    chk("reloaded", 1, compare_output_state_a);
    waveform_mode_select = `T16OC_MODE_PC_A;
    compare_output_action_a = `T16OC_ACT_CLEAR;
    tick(16'h2000);
    chk("up clear", 0, compare_output_state_a);
    count_down = 1'b1;
    tick(16'h2000);
    count_down = 1'b0;
    chk("down set", 1, compare_output_state_a);
    rst = 1'b1;
    step(1);
    rst = 1'b0;
    step(1);
    chk("reset again", 0, compare_output_state_a);
    $display("pwm test done");
  endtask
  initial
  begin
    {timer_tick, count_ceiling, count_floor, count_down, counter_write} = 5'h0;
    {timer_count, waveform_mode_select} = 20'h0;
    {compare_output_action_a, compare_output_action_b} = 4'h0;
    {force_compare_strobe_a, force_compare_strobe_b} = 2'h0;
    {compare_match_irq_enable_a, compare_match_irq_enable_b} = 2'h0;
    {flag_write_one_a, flag_write_one_b, irq_ack_a, irq_ack_b} = 4'h0;
    {port_value_a, port_value_b, output_pin_direction_bit_a, output_pin_direction_bit_b} = 4'h0;
    {fails, check_count} = 64'h0;
    rst = 1'b1;
    step(3);
    rst = 1'b0;
    t_write();
    t_match();
    t_force();
    t_action();
    waveform_mode_select = `T16OC_MODE_FAST_A;
    t_pwm();
    complete_run();
  end
  initial
  begin
    #200000;
    fails++;
    complete_run();
  end
endmodule // t16oc_top_test
bind t16oc_top t16oc_checker u_t16oc_checker (.*);
